// ### dv/periodic_real_time_counter_sva.sv
// Bus and request checks on the periodic counter ports
`timescale 1ns/10ps
module periodic_real_time_counter_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq_request,
  input wire logic wake_request
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  property p_irq_wake;
    irq_request == wake_request;
  endproperty
  a_irq_wake: assert property (p_irq_wake)
    else $error("wake differs from irq");
  property p_irq_fall;
    $fell(irq_request) && $past(aresetn) |-> s_axi_bvalid;
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("irq fell without a write");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("bvalid dropped early");
  property p_b_clear;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_clear: assert property (p_b_clear)
    else $error("bvalid stuck");
  property p_aw_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_block: assert property (p_aw_block)
    else $error("write taken during response");
  property p_w_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_w_ans: assert property (p_w_ans)
    else $error("no write response");
  property p_r_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_ans: assert property (p_r_ans)
    else $error("no read response");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data not held");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block)
    else $error("read taken during response");
  property p_r_upper;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_r_upper: assert property (p_r_upper)
    else $error("upper read bits set");
endmodule // periodic_real_time_counter_sva

bind periodic_real_time_counter periodic_real_time_counter_sva chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .irq_request(irq_request),
  .wake_request(wake_request)
);

// ### dv/test_periodic_real_time_counter.sv
// Testbench for the periodic real-time counter
`timescale 1ns/10ps
module test_periodic_real_time_counter;
  import rtc_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [3:0] awaddr = 0;
  logic [3:0] araddr = 0;
  logic [31:0] wdata = 0;
  logic [31:0] rdata;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic awvalid = 0;
  logic wvalid = 0;
  logic bready = 0;
  logic arvalid = 0;
  logic rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq, wake;
  logic src = 0;
  power_mode_t pm = '0;
  int checks = 0;
  int n_mismatch = 0;

  periodic_real_time_counter dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .low_power_osc_clock(src),
    .external_ref_clock(src), .internal_ref_clock(src),
    .power_mode(pm), .irq_request(irq), .wake_request(wake));

  initial forever #12.5 aclk = ~aclk;

  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk(bresp === resp_okay, "write response");
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e,
                    input logic [1:0] r = resp_okay);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    chk(rdata === {24'h000000, e} && rresp === r, "read value");
  endtask

  // Source edges, one every two bus cycles, then settle
  task automatic edges(input int k);
    repeat (k) begin
      @(posedge aclk);
      src <= 1'b1;
      @(posedge aclk);
      src <= 1'b0;
    end
    repeat (4) @(posedge aclk);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    rd(status_control_addr, 8'h00);
    rd(count_value_addr, 8'h00);
    rd(match_limit_addr, 8'h00);
    rd(4'hc, 8'h00, resp_slverr);
    wr(status_control_addr, 8'h7f);
    rd(status_control_addr, 8'h7f);
    wr(count_value_addr, 8'h55);
    rd(count_value_addr, 8'h00);
  endtask

  task automatic t_wrap();
    wr(match_limit_addr, 8'h03);
    wr(status_control_addr, 8'h08);
    edges(3);
    rd(count_value_addr, 8'h03);
    rd(status_control_addr, 8'h08);
    edges(1);
    rd(count_value_addr, 8'h00);
    rd(status_control_addr, 8'h88);
    chk(irq === 1'b0, "irq while disabled");
    wr(status_control_addr, 8'h18);
    chk(irq === 1'b1 && wake === 1'b1, "irq missing");
    wr(status_control_addr, 8'h98);
    rd(status_control_addr, 8'h18);
    chk(irq === 1'b0, "irq not withdrawn");
  endtask

  task automatic t_ratio();
    edges(1);
    wr(status_control_addr, 8'h01);
    rd(count_value_addr, 8'h00);
    edges(16);
    rd(count_value_addr, 8'h02);
    edges(7);
    rd(count_value_addr, 8'h02);
    wr(status_control_addr, 8'h21);
    rd(count_value_addr, 8'h00);
    wr(status_control_addr, 8'h28);
    edges(999);
    rd(count_value_addr, 8'h00);
    edges(1);
    rd(count_value_addr, 8'h01);
  endtask

  task automatic t_modes();
    pm.deep_stop <= 1'b1;
    edges(1000);
    rd(count_value_addr, 8'h01);
    wr(status_control_addr, 8'h08);
    pm.wait_mode <= 1'b1;
    edges(3);
    rd(count_value_addr, 8'h03);
    pm.debug_active <= 1'b1;
    edges(5);
    rd(count_value_addr, 8'h03);
    pm <= '0;
    edges(1);
    rd(status_control_addr, 8'h88);
    wr(match_limit_addr, 8'h00);
    wr(status_control_addr, 8'h88);
    rd(status_control_addr, 8'h08);
    edges(1);
    rd(status_control_addr, 8'h88);
    rd(count_value_addr, 8'h00);
  endtask

  task automatic t_rerun();
    wr(match_limit_addr, 8'h05);
    wr(status_control_addr, 8'h18);
    chk(irq === 1'b1, "irq before reset");
    pm.shallow_stop <= 1'b1;
    edges(2);
    rd(count_value_addr, 8'h02);
    aresetn <= 1'b0;
    pm <= '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(irq === 1'b0 && wake === 1'b0, "irq after reset");
    rd(status_control_addr, 8'h00);
    rd(match_limit_addr, 8'h00);
    rd(count_value_addr, 8'h00);
  endtask

  task automatic final_report();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_wrap();
    t_ratio();
    t_modes();
    t_rerun();
    final_report();
  end

  initial begin
    repeat (30000) @(posedge aclk);
    n_mismatch++;
    final_report();
  end
endmodule // test_periodic_real_time_counter

// ### hw/periodic_real_time_counter.sv
// Periodic real-time counter with AXI4-Lite register slave
//
// Notes on behaviour
// - One 8-bit up-counter compared with match limit, one periodic interrupt.
// - Source select 00 low-power osc, 01 external ref, 1x internal ref.
// - Changing source select clears prescaler and count.
// - Changing divider select clears prescaler and count.
// - Flag bit 7, source 6-5, irq enable 4, divider 3-0.
// - Flag sets on the tick after count reaches match limit; zero until then.
// - Writing 1 to flag clears it and the request; 0 does nothing.
// - Request asserted while flag set and enable is one.
// - Reset clears flag, enable, source and divider; prescaler off.
// - Binary-bank ratios when source low bit is zero.
// - Decimal-bank ratios when source low bit is one.
// - Counting continues in wait mode; match request can wake.
// - Counting continues in shallow stop; request may wake.
// - In deep stop only low-power osc counts; others halt.
// - Debug mode suspends counting; resumes from held value.
// - At match count wraps to zero on next tick; flag set then.
// - Match limit zero sets flag on every prescaler tick.
// - Any match limit write clears prescaler and count; reset to zero.
// - Count register read-only, writes ignored, reset to zero.
`timescale 1ns/10ps
module periodic_real_time_counter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [rtc_pkg::addr_width-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rtc_pkg::addr_width-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic low_power_osc_clock,
  input wire logic external_ref_clock,
  input wire logic internal_ref_clock,
  input wire rtc_pkg::power_mode_t power_mode,
  output logic irq_request,
  output logic wake_request
);
  import rtc_pkg::*;

  status_control_t status_control;
  logic periodic_match_flag;
  logic [1:0] source_select;
  logic periodic_irq_enable;
  logic [3:0] divider_select;
  logic [7:0] count_value;
  logic [7:0] match_limit;

  logic aw_held;
  logic w_held;
  logic [addr_width-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic write_fire;
  logic read_fire;
  logic write_low_byte;
  logic [7:0] wbyte;

  logic write_status;
  logic write_match;
  logic source_change;
  logic divider_change;
  logic counter_clear;
  logic flag_clear;

  logic selected_clock;
  logic previous_clock;
  logic source_allowed;
  logic source_edge;
  logic prescale_tick;
  logic match_now;

  // ------------------------------------------------------------------
  // Address decode helper
  // ------------------------------------------------------------------
  function automatic logic is_mapped(input logic [addr_width-1:0] a);
    return a == status_control_addr || a == count_value_addr ||
           a == match_limit_addr;
  endfunction

  // ------------------------------------------------------------------
  // Write channels
  // ------------------------------------------------------------------
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign write_fire = aw_held && w_held && !s_axi_bvalid;
  assign write_low_byte = write_fire && w_strb[0];
  assign wbyte = w_data[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
    end else if (write_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_addr <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
    end else if (write_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
    end else if (write_fire) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bresp <= resp_okay;
    end else if (write_fire) begin
      s_axi_bresp <= is_mapped(aw_addr) ? resp_okay : resp_slverr;
    end
  end

  // ------------------------------------------------------------------
  // Read channel
  // ------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign read_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
    end else if (read_fire) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= '0;
      s_axi_rresp <= resp_okay;
    end else if (read_fire) begin
      s_axi_rresp <= is_mapped(s_axi_araddr) ? resp_okay : resp_slverr;
      case (s_axi_araddr)
        status_control_addr: s_axi_rdata <= {24'h0, status_control};
        count_value_addr: s_axi_rdata <= {24'h0, count_value};
        match_limit_addr: s_axi_rdata <= {24'h0, match_limit};
        default: s_axi_rdata <= '0;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------------
  assign write_status = write_low_byte && aw_addr == status_control_addr;
  assign write_match = write_low_byte && aw_addr == match_limit_addr;
  assign source_change = write_status &&
    wbyte[source_hi_bit:source_lo_bit] != status_control.source;
  assign divider_change = write_status &&
    wbyte[divider_hi_bit:divider_lo_bit] != status_control.divider;
  assign counter_clear = source_change || divider_change || write_match;
  assign flag_clear = write_status && wbyte[flag_bit];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      source_select <= source_reset;
      divider_select <= divider_reset;
    end else if (write_status) begin
      source_select <= wbyte[source_hi_bit:source_lo_bit];
      divider_select <= wbyte[divider_hi_bit:divider_lo_bit];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      periodic_irq_enable <= 1'b0;
    end else if (write_status) begin
      periodic_irq_enable <= wbyte[irq_enable_bit];
    end
  end

  // Register image in field order
  assign status_control = {periodic_match_flag, source_select,
    periodic_irq_enable, divider_select};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_limit <= match_reset;
    end else if (write_match) begin
      match_limit <= wbyte;
    end
  end

  // ------------------------------------------------------------------
  // Source selection and edge sampling
  // ------------------------------------------------------------------
  always_comb begin
    case (status_control.source)
      source_low_power: selected_clock = low_power_osc_clock;
      source_external: selected_clock = external_ref_clock;
      default: selected_clock = internal_ref_clock;
    endcase
  end

  // Deep stop keeps only the low-power oscillator; debug freezes all
  assign source_allowed = !power_mode.debug_active &&
    (!power_mode.deep_stop ||
     status_control.source == source_low_power);

  // Starting high hides a false edge after reset or a source switch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      previous_clock <= 1'b1;
    end else if (source_change) begin
      previous_clock <= 1'b1;
    end else begin
      previous_clock <= selected_clock;
    end
  end

  // Wait and shallow stop do not gate counting
  assign source_edge = selected_clock && !previous_clock &&
    source_allowed;

  rtc_prescaler u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(counter_clear),
    .source_edge(source_edge),
    .decimal_bank(status_control.source[0]),
    .divider_select(status_control.divider),
    .tick(prescale_tick)
  );

  // ------------------------------------------------------------------
  // Counter and match flag
  // ------------------------------------------------------------------
  assign match_now = count_value == match_limit;

  always_ff @(posedge aclk) begin
    if (!aresetn || counter_clear) begin
      count_value <= count_reset;
    end else if (prescale_tick) begin
      count_value <= match_now ? 8'h00 : count_value + 8'h01;
    end
  end

  // Set wins over a clear in the same cycle unless the same write also clears the counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      periodic_match_flag <= 1'b0;
    end else if (prescale_tick && match_now && !counter_clear) begin
      periodic_match_flag <= 1'b1;
    end else if (flag_clear) begin
      periodic_match_flag <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Request outputs
  // ------------------------------------------------------------------
  assign irq_request = status_control.match_flag &&
    status_control.irq_enable;
  assign wake_request = irq_request;

endmodule // periodic_real_time_counter

// ### hw/rtc_prescaler.sv
// Prescaler: divides source edges by the selected binary or decimal ratio
`timescale 1ns/10ps
module rtc_prescaler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic source_edge,
  input wire logic decimal_bank,
  input wire logic [3:0] divider_select,
  output logic tick
);
  import rtc_pkg::*;

  logic [rtc_pkg::prescale_width-1:0] phase;
  logic [rtc_pkg::prescale_width-1:0] ratio;

  // ------------------------------------------------------------------
  // Divide ratio lookup
  // ------------------------------------------------------------------
  function automatic logic [prescale_width-1:0] divide_ratio(
    input logic bank, input logic [3:0] code);
    logic [prescale_width-1:0] r;
    r = '0;
    if (!bank) begin
      case (code)
        4'h1: r = 18'd8;
        4'h2: r = 18'd32;
        4'h3: r = 18'd64;
        4'h4: r = 18'd128;
        4'h5: r = 18'd256;
        4'h6: r = 18'd512;
        4'h7: r = 18'd1024;
        4'h8: r = 18'd1;
        4'h9: r = 18'd2;
        4'ha: r = 18'd4;
        4'hb: r = 18'd10;
        4'hc: r = 18'd16;
        4'hd: r = 18'd100;
        4'he: r = 18'd500;
        4'hf: r = 18'd1000;
        default: r = '0;
      endcase
    end else begin
      case (code)
        4'h1: r = 18'd1024;
        4'h2: r = 18'd2048;
        4'h3: r = 18'd4096;
        4'h4: r = 18'd8192;
        4'h5: r = 18'd16384;
        4'h6: r = 18'd32768;
        4'h7: r = 18'd65536;
        4'h8: r = 18'd1000;
        4'h9: r = 18'd2000;
        4'ha: r = 18'd5000;
        4'hb: r = 18'd10000;
        4'hc: r = 18'd20000;
        4'hd: r = 18'd50000;
        4'he: r = 18'd100000;
        4'hf: r = 18'd200000;
        default: r = '0;
      endcase
    end
    return r;
  endfunction

  assign ratio = divide_ratio(decimal_bank, divider_select);

  // ------------------------------------------------------------------
  // Phase counter
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || clear || ratio == '0) begin
      phase <= '0;
      tick <= 1'b0;
    end else if (source_edge) begin
      if (phase == ratio - 18'd1) begin
        phase <= '0;
        tick <= 1'b1;
      end else begin
        phase <= phase + 18'd1;
        tick <= 1'b0;
      end
    end else begin
      tick <= 1'b0;
    end
  end

endmodule // rtc_prescaler

// ### inc/rtc_pkg.sv
// Package: register map, field layout and constants of the periodic counter
package rtc_pkg;

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [3:0] status_control_addr = 4'h0;
  localparam logic [3:0] count_value_addr = 4'h4;
  localparam logic [3:0] match_limit_addr = 4'h8;
  localparam int addr_width = 4;

  // ------------------------------------------------------------------
  // Status/control field positions
  // ------------------------------------------------------------------
  localparam int flag_bit = 7;
  localparam int source_hi_bit = 6;
  localparam int source_lo_bit = 5;
  localparam int irq_enable_bit = 4;
  localparam int divider_hi_bit = 3;
  localparam int divider_lo_bit = 0;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] count_reset = 8'h00;
  localparam logic [7:0] match_reset = 8'h00;
  localparam logic [1:0] source_reset = 2'h0;
  localparam logic [3:0] divider_reset = 4'h0;

  // ------------------------------------------------------------------
  // Source select codes
  // ------------------------------------------------------------------
  localparam logic [1:0] source_low_power = 2'h0;
  localparam logic [1:0] source_external = 2'h1;

  // ------------------------------------------------------------------
  // Prescaler and bus constants
  // ------------------------------------------------------------------
  localparam int prescale_width = 18;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic match_flag;
    logic [1:0] source;
    logic irq_enable;
    logic [3:0] divider;
  } status_control_t;

  typedef struct packed {
    logic wait_mode;
    logic deep_stop;
    logic shallow_stop;
    logic debug_active;
  } power_mode_t;

endpackage
